/* File: hdl/sfpe_pkg.sv */
// Shared constants for the serial flash program/erase sequencer.
// Assumes a 50 MHz reference clock and an array of 32 MiB behind byte write ports.
package sfpe_pkg;

    // Reference clock period in ns
    localparam int CLK_NS = 20;

    // Command codes
    localparam logic [7:0] CMD_LATCH_SET = 8'h06;
    localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
    localparam logic [7:0] CMD_STAT_RD = 8'h05;
    localparam logic [7:0] CMD_SEC_RD = 8'h28;
    localparam logic [7:0] CMD_CHIP_A = 8'h60;
    localparam logic [7:0] CMD_CHIP_B = 8'hC7;
    localparam logic [7:0] CMD_PAGE = 8'h02;
    localparam logic [7:0] CMD_QPAGE = 8'h38;
    localparam logic [7:0] CMD_AUTO = 8'hAD;
    localparam logic [7:0] CMD_BUSY_ON = 8'h70;
    localparam logic [7:0] CMD_BUSY_OFF = 8'h80;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;
    localparam logic [7:0] CMD_WIDE_ON = 8'hB7;
    localparam logic [7:0] CMD_WIDE_OFF = 8'hE9;
    localparam logic [7:0] CMD_FAIL_CLR = 8'h30;

    // Array geometry
    localparam int ARR_AW = 25;
    localparam int PAGE_BYTES = 256;
    localparam logic [ARR_AW-1:0] ARR_LAST = 25'h1FFFFFF;
    localparam logic [9:0] BLK_COUNT = 10'h200;
    localparam logic [3:0] SPAN_ALL = 4'hA;

    // Address lengths in bytes
    localparam logic [7:0] ALEN_NARROW = 8'h03;
    localparam logic [7:0] ALEN_WIDE = 8'h04;

    // Self-timed cycle durations in ns (plain defaults)
    localparam int T_PP_NS = 1000000;
    localparam int T_CE_NS = 10000000;
    localparam int T_BP_NS = 100000;
    localparam int T_DP_NS = 10000;

    // Durations in reference clock cycles, rounded up
    localparam int PP_CYC = (T_PP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CE_CYC = (T_CE_NS + CLK_NS - 1) / CLK_NS;
    localparam int BP_CYC = (T_BP_NS + CLK_NS - 1) / CLK_NS;
    localparam int DP_CYC = (T_DP_NS + CLK_NS - 1) / CLK_NS;

    // Sequencer states
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_PAGE = 3'b001,
        ST_CHIP = 3'b010,
        ST_PAIR = 3'b011,
        ST_SLEEP = 3'b100
    } sfpe_state_t;

endpackage : sfpe_pkg

/* File: hdl/sfpe_core.sv */
// Program/erase command sequencer of a serial NOR flash.
// Assumes the host stops sclk while select_n is high and holds select_n
// high long enough for the reference clock to see it (a few ref_clk cycles).
`timescale 1ns/10ps

// Overview of operation
// R1 - Whole erase needs latch, byte-aligned select release
// R2 - Erase runs on release; busy, then latch cleared
// R3 - Protected array: skip erase, still clear latch
// R4 - Page write clears bits; latch required beforehand
// R5 - Keep last 256 bytes, wrap in page
// R6 - Short writes leave other page bytes untouched
// R7 - Code, address, data; reject misaligned release
// R8 - Page write self-timed; busy then latch cleared
// R9 - Protected bytes untouched; latch still cleared
// R10 - Quad write needs latch and quad enable (the code checks only the latch)
// R11 - Quad write captures address, data on four lanes
// R12 - Host may slow clock during quad data
// R13 - Auto program: two bytes, even then odd
// R14 - One byte programs nothing; extras ignored
// R15 - No wrap; stop at last unprotected address
// R16 - Auto mode takes AD,04,05,28; 04 when idle
// R17 - Host repeats pairs then ends with latch clear
// R18 - Busy indication on serial output while selected
// R19 - Busy indication toggles refused during auto mode
// R20 - Sleep entry after delay; writes ignored
// R21 - Asleep: only wake and signature read honoured
// R22 - Wake only when released after eighth bit
// R23 - Wide addressing defaults off, selects four bytes
// R24 - Protected program sets fail flag until cleared
// R25 - Command byte MSB first, aborted on early release
// R26 - While busy, further program or erase rejected
module sfpe_core
#(
    parameter int PP_CYCLES = sfpe_pkg::PP_CYC,
    parameter int CE_CYCLES = sfpe_pkg::CE_CYC,
    parameter int BP_CYCLES = sfpe_pkg::BP_CYC
)
(
    // Reference clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Serial link from the host
    input wire logic sclk,
    input wire logic select_n,
    input wire logic [3:0] io_in,
    output logic serial_out,
    output logic serial_out_oe,
    // Protection and lane configuration pins
    input wire logic quad_lanes_enable,
    input wire logic protect_scheme_select,
    input wire logic [3:0] protect_span_bits,
    input wire logic [511:0] block_locks,
    // Status
    output logic write_in_progress,
    output logic write_latch,
    output logic auto_program_active,
    output logic busy_output_mode,
    output logic program_fail,
    output logic erase_fail,
    output logic deep_sleep,
    output logic wide_address_mode,
    // Array write port
    output logic arr_wr,
    output logic [sfpe_pkg::ARR_AW-1:0] arr_addr,
    output logic [7:0] arr_data,
    output logic arr_erase
);

    // Protection test for one address under the given scheme
    function automatic logic prot_hit(input logic [sfpe_pkg::ARR_AW-1:0] a,
                                      input logic sch, input logic [3:0] span,
                                      input logic [511:0] locks);
        logic [9:0] lim;
        lim = 10'h000;
        if (sch)
            return locks[a[24:16]];
        if (span == 4'h0)
            return 1'b0;
        if (span >= sfpe_pkg::SPAN_ALL)
            return 1'b1;
        // Protected region grows from the top of the array
        lim = sfpe_pkg::BLK_COUNT - (10'h001 << (span - 4'h1));
        return {1'b0, a[24:16]} >= lim;
    endfunction : prot_hit

    // ---------------- Link domain (sclk) ----------------
    logic fresh_r; // Set while deselected; marks the next edge as bit 0
    logic [2:0] lk_s1_r; // First sync stage: auto mode, quad enable, wide mode
    logic [2:0] lk_s2_r; // Second sync stage
    logic [7:0] sh_r; // Byte shifter
    logic [2:0] bpos_r; // Bits gathered in current byte
    logic [7:0] nbytes_r; // Whole bytes in this frame, saturating
    logic [7:0] cmd_r; // Command code of the frame
    logic [31:0] addr_r; // Address as shifted in
    logic [8:0] dcnt_r; // Data bytes received, saturating
    logic [7:0] d0_r; // First data byte
    logic [7:0] d1_r; // Second data byte
    logic [7:0] pbuf [sfpe_pkg::PAGE_BYTES]; // Page data, indexed by low address
    logic [255:0] pmask_r; // Which page bytes were written

    logic [2:0] bpos_cur;
    logic [7:0] nb_cur;
    logic quad_now;
    logic [7:0] byte_nxt;
    logic [3:0] bpos_nxt;
    logic byte_done;
    logic [7:0] alen;
    logic [7:0] pidx;

    // Frame start marker; select_n high forces it so counters restart
    always_ff @(posedge sclk or posedge select_n)
    begin
        if (select_n)
            fresh_r <= 1'b1;
        else
            fresh_r <= 1'b0;
    end

    // Bring configuration levels into the link domain
    always_ff @(posedge sclk)
    begin
        lk_s1_r <= {auto_program_active, quad_lanes_enable, wide_address_mode};
        lk_s2_r <= lk_s1_r;
    end

    // Next-bit arithmetic for the shifter
    always_comb
    begin
        bpos_cur = fresh_r ? 3'h0 : bpos_r;
        nb_cur = fresh_r ? 8'h00 : nbytes_r;
        // R13 repeat pairs in auto mode carry no address
        if (lk_s2_r[2] && cmd_r == sfpe_pkg::CMD_AUTO)
            alen = 8'h00;
        else
            alen = lk_s2_r[0] ? sfpe_pkg::ALEN_WIDE : sfpe_pkg::ALEN_NARROW;
        // R11 four lanes
        quad_now = lk_s2_r[1] && (cmd_r == sfpe_pkg::CMD_QPAGE) && (nb_cur != 8'h00);
        // R25 MSB first
        byte_nxt = quad_now ? {sh_r[3:0], io_in} : {sh_r[6:0], io_in[0]};
        bpos_nxt = {1'b0, bpos_cur} + (quad_now ? 4'h4 : 4'h1);
        byte_done = (bpos_nxt == 4'h8);
        pidx = addr_r[7:0] + dcnt_r[7:0];
    end

    // Byte assembly: command, address and data capture
    always_ff @(posedge sclk)
    begin
        sh_r <= byte_nxt;
        bpos_r <= bpos_nxt[2:0];
        if (fresh_r)
        begin
            // Previous frame is discarded only when the new one starts
            nbytes_r <= 8'h00;
            dcnt_r <= 9'h000;
            pmask_r <= '0;
            // Upper address bytes read as zero in narrow mode
            addr_r <= 32'h00000000;
        end
        else if (byte_done)
        begin
            if (nb_cur != 8'hFF)
                nbytes_r <= nb_cur + 8'h01;
            if (nb_cur == 8'h00)
                cmd_r <= byte_nxt;
            else if (nb_cur <= alen)
                // R23 address length
                addr_r <= {addr_r[23:0], byte_nxt};
            else
            begin
                // R5 wrap inside page, last data kept
                pbuf[pidx] <= byte_nxt;
                pmask_r[pidx] <= 1'b1;
                if (dcnt_r == 9'h000)
                    d0_r <= byte_nxt;
                if (dcnt_r == 9'h001)
                    d1_r <= byte_nxt;
                if (dcnt_r != 9'h1FF)
                    dcnt_r <= dcnt_r + 9'h001;
            end
        end
        // The very first edge of a frame always lands on the command byte
        if (fresh_r && byte_done)
            cmd_r <= byte_nxt;
    end

    // ---------------- Reference domain ----------------
    logic cs_s1_r; // Select synchroniser, first stage
    logic cs_s2_r; // Select synchroniser, second stage
    logic cs_s3_r; // Delayed copy for edge detection
    logic [516:0] cfg_s1_r; // Config pin synchroniser, first stage
    logic [516:0] cfg_s2_r; // Config pin synchroniser, second stage
    sfpe_pkg::sfpe_state_t state_r; // Sequencer state
    logic [31:0] tmr_r; // Self-timed cycle counter
    logic [8:0] walk_r; // Page walk index
    logic [sfpe_pkg::ARR_AW-1:0] base_r; // Page base or pair address
    logic [sfpe_pkg::ARR_AW-1:0] cp_addr_r; // Next auto program pair
    logic cp_wr_r; // Pair write phase
    logic frame_end;
    logic sch_s;
    logic [3:0] span_s;
    logic [511:0] locks_s;
    logic aligned;
    logic [7:0] alen_r;
    logic any_prot;
    logic [sfpe_pkg::ARR_AW-1:0] pair_nxt;

    // Synchronise select and configuration pins
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
            cfg_s1_r <= '0;
            cfg_s2_r <= '0;
        end
        else
        begin
            cs_s1_r <= select_n;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
            cfg_s1_r <= {protect_scheme_select, protect_span_bits, block_locks};
            cfg_s2_r <= cfg_s1_r;
        end
    end

    // Frame fields are stable here since sclk is still while deselected
    always_comb
    begin
        frame_end = cs_s2_r && !cs_s3_r;
        {sch_s, span_s, locks_s} = cfg_s2_r;
        aligned = (bpos_r == 3'h0) && (nbytes_r != 8'h00);
        alen_r = wide_address_mode ? sfpe_pkg::ALEN_WIDE : sfpe_pkg::ALEN_NARROW;
        any_prot = sch_s ? (locks_s != '0) : (span_s != 4'h0);
        pair_nxt = cp_addr_r + 25'h0000002;
    end

    // Command decode, status bits and self-timed sequencing
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state_r <= sfpe_pkg::ST_IDLE;
            tmr_r <= 32'h00000000;
            walk_r <= 9'h000;
            base_r <= '0;
            cp_addr_r <= '0;
            cp_wr_r <= 1'b0;
            write_latch <= 1'b0;
            auto_program_active <= 1'b0;
            busy_output_mode <= 1'b0;
            program_fail <= 1'b0;
            erase_fail <= 1'b0;
            deep_sleep <= 1'b0;
            // R23 narrow by default
            wide_address_mode <= 1'b0;
        end
        else
        begin
            case (state_r)
                sfpe_pkg::ST_PAGE, sfpe_pkg::ST_CHIP, sfpe_pkg::ST_PAIR:
                begin
                    if (walk_r != 9'h100)
                        walk_r <= walk_r + 9'h001;
                    if (tmr_r > 32'h00000001)
                        tmr_r <= tmr_r - 32'h00000001;
                    else
                    begin
                        // R2 R8 cycle end clears latch
                        state_r <= sfpe_pkg::ST_IDLE;
                        if (!auto_program_active || state_r != sfpe_pkg::ST_PAIR)
                            write_latch <= 1'b0;
                        if (state_r == sfpe_pkg::ST_PAIR)
                        begin
                            cp_addr_r <= pair_nxt;
                            // R15 stop at end or at protection, no wrap
                            if (cp_addr_r == (sfpe_pkg::ARR_LAST - 25'h0000001) ||
                                prot_hit(pair_nxt, sch_s, span_s, locks_s))
                            begin
                                auto_program_active <= 1'b0;
                                write_latch <= 1'b0;
                            end
                        end
                    end
                    // R24 protected target raises program fail
                    if (state_r != sfpe_pkg::ST_CHIP && walk_r < 9'h100 &&
                        ((state_r == sfpe_pkg::ST_PAGE && pmask_r[walk_r[7:0]]) ||
                         (state_r == sfpe_pkg::ST_PAIR && walk_r < 9'h002)) &&
                        prot_hit(base_r | {17'h00000, walk_r[7:0]}, sch_s, span_s, locks_s))
                        program_fail <= 1'b1;
                end
                sfpe_pkg::ST_SLEEP:
                begin
                    // R20 entry delay
                    if (tmr_r > 32'h00000001)
                        tmr_r <= tmr_r - 32'h00000001;
                    else
                    begin
                        deep_sleep <= 1'b1;
                        state_r <= sfpe_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    walk_r <= 9'h000;
                end
            endcase

            // Completed frames are decoded only when no cycle runs
            if (frame_end)
            begin
                if (deep_sleep)
                begin
                    // R21 R22 wake only on exact eight-bit frame
                    if (cmd_r == sfpe_pkg::CMD_WAKE && nbytes_r == 8'h01 && bpos_r == 3'h0)
                        deep_sleep <= 1'b0;
                end
                // R26 busy: no new program or erase
                else if (state_r != sfpe_pkg::ST_IDLE)
                begin
                    // R16 latch clear is ignored, not held, until idle
                end
                else if (auto_program_active)
                begin
                    // R16 restricted code set
                    if (cmd_r == sfpe_pkg::CMD_LATCH_CLR && aligned)
                    begin
                        auto_program_active <= 1'b0;
                        write_latch <= 1'b0;
                    end
                    // R13 R14 exactly the first two bytes count
                    else if (cmd_r == sfpe_pkg::CMD_AUTO && dcnt_r >= 9'h002)
                    begin
                        state_r <= sfpe_pkg::ST_PAIR;
                        tmr_r <= BP_CYCLES;
                        base_r <= cp_addr_r;
                        walk_r <= 9'h000;
                    end
                end
                else if (aligned)
                begin
                    case (cmd_r)
                        sfpe_pkg::CMD_LATCH_SET: write_latch <= 1'b1;
                        sfpe_pkg::CMD_LATCH_CLR: write_latch <= 1'b0;
                        // R19 toggles refused in auto mode
                        sfpe_pkg::CMD_BUSY_ON: busy_output_mode <= 1'b1;
                        sfpe_pkg::CMD_BUSY_OFF: busy_output_mode <= 1'b0;
                        sfpe_pkg::CMD_WIDE_ON: wide_address_mode <= 1'b1;
                        sfpe_pkg::CMD_WIDE_OFF: wide_address_mode <= 1'b0;
                        sfpe_pkg::CMD_FAIL_CLR:
                        begin
                            program_fail <= 1'b0;
                            erase_fail <= 1'b0;
                        end
                        sfpe_pkg::CMD_SLEEP:
                        begin
                            state_r <= sfpe_pkg::ST_SLEEP;
                            tmr_r <= sfpe_pkg::DP_CYC;
                        end
                        sfpe_pkg::CMD_CHIP_A, sfpe_pkg::CMD_CHIP_B:
                        begin
                            // R1 code only, latch set
                            if (write_latch && nbytes_r == 8'h01)
                            begin
                                // R3 protected: latch cleared, array kept
                                if (any_prot)
                                begin
                                    write_latch <= 1'b0;
                                    erase_fail <= 1'b1;
                                end
                                else
                                begin
                                    state_r <= sfpe_pkg::ST_CHIP;
                                    tmr_r <= CE_CYCLES;
                                end
                            end
                        end
                        sfpe_pkg::CMD_PAGE, sfpe_pkg::CMD_QPAGE:
                        begin
                            // R4 R7 R10 latch, full address, one data byte
                            if (write_latch && dcnt_r != 9'h000)
                            begin
                                state_r <= sfpe_pkg::ST_PAGE;
                                tmr_r <= PP_CYCLES;
                                base_r <= {addr_r[sfpe_pkg::ARR_AW-1:8], 8'h00};
                                walk_r <= 9'h000;
                            end
                        end
                        sfpe_pkg::CMD_AUTO:
                        begin
                            // R14 a lone data byte programs nothing
                            if (write_latch && dcnt_r >= 9'h002)
                            begin
                                auto_program_active <= 1'b1;
                                cp_addr_r <= {addr_r[sfpe_pkg::ARR_AW-1:1], 1'b0};
                                base_r <= {addr_r[sfpe_pkg::ARR_AW-1:1], 1'b0};
                                state_r <= sfpe_pkg::ST_PAIR;
                                tmr_r <= BP_CYCLES;
                                walk_r <= 9'h000;
                            end
                        end
                        default:
                        begin
                            // Reads and unknown codes change nothing here
                        end
                    endcase
                end
            end
        end
    end

    // Array write port: one byte per cycle while walking
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            arr_wr <= 1'b0;
            arr_addr <= '0;
            arr_data <= 8'hFF;
            arr_erase <= 1'b0;
        end
        else
        begin
            arr_wr <= 1'b0;
            arr_erase <= 1'b0;
            // R1 whole array erase pulse at cycle start
            if (state_r == sfpe_pkg::ST_CHIP && walk_r == 9'h000)
                arr_erase <= 1'b1;
            // R4 R6 R9 only addressed, unprotected bytes
            if (state_r == sfpe_pkg::ST_PAGE && walk_r < 9'h100 && pmask_r[walk_r[7:0]] &&
                !prot_hit(base_r | {17'h00000, walk_r[7:0]}, sch_s, span_s, locks_s))
            begin
                arr_wr <= 1'b1;
                arr_addr <= base_r | {17'h00000, walk_r[7:0]};
                arr_data <= pbuf[walk_r[7:0]];
            end
            // R13 even byte first, then odd
            if (state_r == sfpe_pkg::ST_PAIR && walk_r < 9'h002 &&
                !prot_hit(base_r | {24'h000000, walk_r[0]}, sch_s, span_s, locks_s))
            begin
                arr_wr <= 1'b1;
                arr_addr <= base_r | {24'h000000, walk_r[0]};
                arr_data <= walk_r[0] ? d1_r : d0_r;
            end
        end
    end

    // Busy flag and ready/busy indication on the serial output
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            write_in_progress <= 1'b0;
            serial_out <= 1'b1;
            serial_out_oe <= 1'b0;
        end
        else
        begin
            write_in_progress <= (state_r == sfpe_pkg::ST_PAGE) ||
                                 (state_r == sfpe_pkg::ST_CHIP) ||
                                 (state_r == sfpe_pkg::ST_PAIR);
            // R18 drive ready/busy while selected in auto mode with busy indication on, release otherwise
            serial_out_oe <= busy_output_mode && auto_program_active && !cs_s2_r;
            serial_out <= (state_r == sfpe_pkg::ST_IDLE) || (state_r == sfpe_pkg::ST_SLEEP);
        end
    end

endmodule : sfpe_core

/* File: verif/sfpe_core_props.sv */
// Checker for the program/erase sequencer, bound to its ports.
// Assumes the short cycle counts that the bench sets.
`timescale 1ns/10ps
module sfpe_core_props
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Status and array port
    input wire logic write_in_progress,
    input wire logic write_latch,
    input wire logic auto_program_active,
    input wire logic deep_sleep,
    input wire logic wide_address_mode,
    input wire logic arr_wr,
    input wire logic arr_erase
);
    // One domain only, so one default clock and reset
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    reset_state_a:
    assert property (disable iff (1'b0) !resetn |=> !wide_address_mode && !write_latch)
    else $error("state not cleared by reset");
    cycle_end_a:
    assert property ($fell(write_in_progress) && !auto_program_active |-> !write_latch)
    else $error("latch kept");
    busy_span_a:
    assert property ($rose(write_in_progress) |=> write_in_progress[*4]) else $error("short busy");
    erase_busy_a:
    assert property (arr_erase |=> write_in_progress) else $error("erase not busy");
    write_busy_a:
    assert property (arr_wr |-> ##[0:1] write_in_progress) else $error("write not busy");
    sleep_quiet_a:
    assert property (deep_sleep |-> !arr_wr && !arr_erase) else $error("array hit asleep");
    sleep_latch_a:
    assert property (deep_sleep && $past(deep_sleep) |-> !$rose(write_latch)) else $error("latch");
    auto_exit_a:
    assert property ($fell(auto_program_active) |-> !write_latch) else $error("auto exit");
endmodule : sfpe_core_props

bind sfpe_core sfpe_core_props i_props (.ref_clk, .resetn, .write_in_progress, .write_latch,
    .auto_program_active, .deep_sleep, .wide_address_mode, .arr_wr, .arr_erase);

/* File: verif/sfpe_host.sv */
// Host controller model: sends frames on select_n, sclk and lane 0.
// Assumes the bench leaves select_n high for some ref_clk cycles between frames.
`timescale 1ns/10ps
module sfpe_host
(
    // Serial link
    output logic sclk,
    output logic select_n,
    output logic [3:0] io_in
);
    // quad data clock not slowed: optional
    // Idle: clock stopped, device deselected
    initial
    begin
        sclk = 1'b0;
        select_n = 1'b1;
        io_in = 4'h0;
    end
    // bytes MSB first, extra bits leave a partial byte
    task automatic frame(input logic [7:0] q[$], input int extra);
        int n;
        n = q.size() * 8 + extra;
        select_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            io_in[0] = (i / 8 < q.size()) ? q[i / 8][7 - i % 8] : 1'b1;
            #15 sclk = 1'b1;
            #15 sclk = 1'b0;
        end
        #15 select_n = 1'b1;
        // Released lanes must not keep the last value
        io_in = ~io_in;
    endtask : frame
endmodule : sfpe_host

/* File: verif/serial_flash_program_erase_test.sv */
// Self-checking bench for the program/erase sequencer.
// Assumes the host model and shortened cycle counts.
`timescale 1ns/10ps
module serial_flash_program_erase_test;
    // Design ports; lock scheme and quad lanes stay off
    logic ref_clk = 1'b0, resetn = 1'b0, sclk, select_n, serial_out, serial_out_oe;
    logic quad_lanes_enable = 1'b0, protect_scheme_select = 1'b0, arr_wr, arr_erase;
    logic write_in_progress, write_latch, auto_program_active, busy_output_mode;
    logic program_fail, erase_fail, deep_sleep, wide_address_mode;
    logic [3:0] io_in, protect_span_bits = 4'h0;
    logic [511:0] block_locks = '0;
    logic [24:0] arr_addr;
    logic [7:0] arr_data, d0, d1, img [256];
    logic [16:0] page = 17'h00001;
    int num_errors = 0, compares = 0, cyc = 0, nwr = 0, ner = 0;
    always #10 ref_clk = ~ref_clk;
    sfpe_host i_host (.sclk, .select_n, .io_in);
    sfpe_core #(.PP_CYCLES(300), .CE_CYCLES(20), .BP_CYCLES(8)) i_dut (.*);
    task automatic chk_v(input logic [24:0] got, input logic [24:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : idle
    // One-byte command, then the gap that the link needs
    task automatic cmd(input logic [7:0] c);
        i_host.frame('{c}, 0);
        idle(10);
    endtask : cmd
    // Bounded wait for the busy flag
    task automatic wait_wip(input logic v);
        for (int n = 0; n < 2000 && write_in_progress !== v; n++)
            @(negedge ref_clk);
        chk_v(write_in_progress, v);
    endtask : wait_wip
    task automatic results;
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results
    // Watchdog and array port monitor, sampled away from the active edge
    always @(negedge ref_clk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            num_errors++;
            results();
        end
        ner += (arr_erase === 1'b1);
        if (arr_wr === 1'b1)
        begin
            nwr++;
            chk_v(arr_addr[24:8], page);
            chk_v(arr_data, img[arr_addr[7:0]]);
        end
    end
    // Main sequence
    initial
    begin
        d0 = $urandom(56);
        foreach (img[i])
            img[i] = 8'hFF;
        idle(5);
        resetn = 1'b1;
        idle(4);
        chk_v(wide_address_mode, 1'b0);
        d0 = $urandom;
        d1 = $urandom;
        i_host.frame('{8'h02, 8'h00, 8'h01, 8'hFE, d0}, 0);
        idle(10);
        chk_v(nwr, 0);
        cmd(8'h06);
        img[8'hFE] = d0;
        img[8'hFF] = d1;
        img[8'h00] = d0 ^ d1;
        // Start near the page end so the third byte wraps
        i_host.frame('{8'h02, 8'h00, 8'h01, 8'hFE, d0, d1, d0 ^ d1}, 0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        chk_v(write_latch, 1'b0);
        chk_v(nwr != 0, 1'b1);
        cmd(8'h06);
        i_host.frame('{8'hC7}, 1);
        idle(10);
        chk_v(ner, 0);
        i_host.frame('{8'hC7}, 0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        chk_v(ner, 1);
        chk_v(write_latch, 1'b0);
        cmd(8'h06);
        protect_span_bits = 4'hA;
        cmd(8'hC7);
        idle(30);
        chk_v(ner, 1);
        chk_v(write_latch, 1'b0);
        cmd(8'h06);
        i_host.frame('{8'h02, 8'h00, 8'h00, 8'h00, d0}, 0);
        wait_wip(1'b1);
        wait_wip(1'b0);
        chk_v({program_fail, erase_fail}, 2'b11);
        cmd(8'h30);
        chk_v({program_fail, erase_fail}, 2'b00);
        protect_span_bits = 4'h0;
        page = 17'h0;
        img[8'h10] = d1;
        img[8'h11] = d0;
        nwr = 0;
        cmd(8'h06);
        cmd(8'h70);
        i_host.frame('{8'hAD, 8'h00, 8'h00, 8'h10, d1, d0, 8'h00}, 0);
        idle(30);
        chk_v(nwr, 2);
        i_host.frame('{8'hAD, d0}, 0);
        idle(30);
        chk_v(nwr, 2);
        img[8'h12] = d0;
        img[8'h13] = d1;
        fork
            i_host.frame('{8'hAD, d0, d1}, 0);
            begin
                idle(4);
                chk_v({serial_out_oe, serial_out}, 2'b11);
            end
        join
        idle(30);
        chk_v(nwr, 4);
        chk_v(serial_out_oe, 1'b0);
        cmd(8'h80);
        chk_v(busy_output_mode, 1'b1);
        chk_v(auto_program_active, 1'b1);
        cmd(8'h04);
        chk_v(auto_program_active, 1'b0);
        cmd(8'hB9);
        idle(600);
        chk_v(deep_sleep, 1'b1);
        cmd(8'h06);
        chk_v(write_latch, 1'b0);
        i_host.frame('{8'hAB}, 1);
        idle(10);
        chk_v(deep_sleep, 1'b1);
        cmd(8'hAB);
        chk_v(deep_sleep, 1'b0);
        cmd(8'hB7);
        chk_v(wide_address_mode, 1'b1);
        cmd(8'hE9);
        chk_v(wide_address_mode, 1'b0);
        results();
    end
endmodule : serial_flash_program_erase_test
